// file: hw/bsl_consts.vh
// constants for the burst sequencing and latency block
`ifndef BSL_CONSTS_VH
`define BSL_CONSTS_VH
`define BSL_LAT_CODE_5      4'h0
`define BSL_LAT_CODE_6      4'h1
`define BSL_LAT_CODE_7      4'h2
`define BSL_LAT_CODE_3      4'hE
`define BSL_LAT_CODE_4      4'hF
`define BSL_LAT_RESET_CODE  4'h2
`define BSL_LAT_RESET_CLKS  3'h7
`define BSL_LAT_MIN_CLKS    3'h3
`define BSL_HYB_RESET       1'b1
`define BSL_FIXED_RESET     1'b1
`define BSL_BURST_LEN_RESET 2'h3
`define BSL_BURST_LINEAR    1'b1
`define BSL_WLEN_128        2'h0
`define BSL_WLEN_64         2'h1
`define BSL_WLEN_16         2'h2
`define BSL_WLEN_32         2'h3
`define BSL_CFG0_LAT_HI     7
`define BSL_CFG0_LAT_LO     4
`define BSL_CFG0_FIXED      3
`define BSL_CFG0_HYB        2
`define BSL_CFG0_LEN_HI     1
`define BSL_CFG0_LEN_LO     0
`define BSL_CFG1_BTYPE      7
`define BSL_ADDR_STEP       32'h00000002
`endif

// file: hw/bsl_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module bsl_sync
(
  input  wire ref_clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      // rest at the idle level of the active-low select, so reset shows no false frame
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_o <= 1'b1;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only once stages two and three agree
      if (s2_q == s3_q)
        level_o <= s3_q;
    end
  end
endmodule

// file: hw/bsl_core.v
// burst address sequencing and initial latency control
`timescale 1ns/100ps
`include "bsl_consts.vh"
module bsl_core
(
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        chip_sel_n_i,
  input  wire        ca_done_i,
  input  wire        ca_reg_space_i,
  input  wire        ca_read_i,
  input  wire        ca_burst_linear_i,
  input  wire [31:0] ca_addr_i,
  input  wire        advance_i,
  input  wire        refresh_due_i,
  input  wire        cfg0_we_i,
  input  wire [15:0] cfg0_wdata_i,
  input  wire        cfg1_we_i,
  input  wire [15:0] cfg1_wdata_i,
  output reg  [31:0] addr_o,
  output reg         rwds_o,
  output reg         rwds_oe_o,
  output reg         data_phase_o,
  output reg         reg_capture_o,
  output reg         refresh_go_o,
  output reg  [3:0]  lat_code_o,
  output reg         lat_code_bad_o
);
  ////////////////////////////////////////////////////////////////////////
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CA   = 4'h2;
  localparam [3:0] ST_LAT  = 4'h4;
  localparam [3:0] ST_DATA = 4'h8;

  // unknown codes fall back to the longest latency, the safe side
  function [2:0] lat_clks;
    input [3:0] code;
    begin
      case (code)
        `BSL_LAT_CODE_5: lat_clks = 3'h5;
        `BSL_LAT_CODE_6: lat_clks = 3'h6;
        `BSL_LAT_CODE_7: lat_clks = 3'h7;
        `BSL_LAT_CODE_3: lat_clks = 3'h3;
        `BSL_LAT_CODE_4: lat_clks = 3'h4;
        default:         lat_clks = `BSL_LAT_RESET_CLKS;
      endcase
    end
  endfunction

  function [7:0] wrap_mask;
    input [1:0] len;
    begin
      case (len)
        `BSL_WLEN_128: wrap_mask = 8'h7F;
        `BSL_WLEN_64:  wrap_mask = 8'h3F;
        `BSL_WLEN_16:  wrap_mask = 8'h0F;
        default:       wrap_mask = 8'h1F;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  wire cs_n;
  bsl_sync u_cs_sync
  (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (chip_sel_n_i),
    .level_o   (cs_n)
  );

  reg [3:0]  lat_q;
  reg        fixed_q;
  reg        hyb_q;
  reg [1:0]  wlen_q;
  reg        btype_q;
  reg [3:0]  st_q;
  reg [3:0]  cnt_q;
  reg        wrap_q;
  reg        hyb_act_q;
  reg [7:0]  start_q;
  reg [31:0] group_q;

  wire [7:0]  msk      = wrap_mask(wlen_q);
  wire [31:0] mask32   = {24'h000000, msk};
  wire [31:0] next_lin = addr_o + `BSL_ADDR_STEP;
  wire [31:0] next_wrp = (addr_o & ~mask32) | (next_lin & mask32);
  wire [7:0]  next_low = next_wrp[7:0] & msk;
  wire        wrap_end = (next_low == start_q);
  wire        lat_txn  = ca_read_i | ~ca_reg_space_i;
  wire        dbl      = fixed_q | refresh_due_i;
  wire [3:0]  one_lat  = {1'b0, lat_clks(lat_q)};
  wire        wrapped  = ~(ca_burst_linear_i & btype_q);

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      lat_q <= `BSL_LAT_RESET_CODE;
      fixed_q <= `BSL_FIXED_RESET;
      hyb_q <= `BSL_HYB_RESET;
      wlen_q <= `BSL_BURST_LEN_RESET;
      btype_q <= `BSL_BURST_LINEAR;
    end
    else
    begin
      if (cfg0_we_i)
      begin
        lat_q   <= cfg0_wdata_i[`BSL_CFG0_LAT_HI:`BSL_CFG0_LAT_LO];
        fixed_q <= cfg0_wdata_i[`BSL_CFG0_FIXED];
        hyb_q   <= cfg0_wdata_i[`BSL_CFG0_HYB];
        wlen_q  <= cfg0_wdata_i[`BSL_CFG0_LEN_HI:`BSL_CFG0_LEN_LO];
      end
      if (cfg1_we_i)
        btype_q <= cfg1_wdata_i[`BSL_CFG1_BTYPE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q           <= ST_IDLE;
      cnt_q          <= 4'h0;
      wrap_q         <= 1'b0;
      hyb_act_q      <= 1'b0;
      start_q        <= 8'h00;
      group_q        <= 32'h00000000;
      addr_o         <= 32'h00000000;
      rwds_o         <= 1'b0;
      rwds_oe_o      <= 1'b0;
      data_phase_o   <= 1'b0;
      reg_capture_o  <= 1'b0;
      refresh_go_o   <= 1'b0;
      lat_code_o     <= `BSL_LAT_RESET_CODE;
      lat_code_bad_o <= 1'b0;
    end
    else
    begin
      lat_code_o     <= lat_q;
      lat_code_bad_o <= (lat_clks(lat_q) == `BSL_LAT_RESET_CLKS) && (lat_q != `BSL_LAT_CODE_7);
      refresh_go_o   <= 1'b0;
      if (cs_n)
      begin
        // select high ends any burst at once
        st_q         <= ST_IDLE;
        rwds_o       <= 1'b0;
        rwds_oe_o    <= 1'b0;
        data_phase_o <= 1'b0;
        reg_capture_o <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_IDLE:
          begin
            st_q      <= ST_CA;
            rwds_oe_o <= 1'b1;
            // strobe shows double latency, fixed mode or refresh need; for register writes it is don't care
            rwds_o    <= fixed_q | refresh_due_i;
          end
          ST_CA:
          begin
            if (ca_done_i)
            begin
              rwds_oe_o <= 1'b0;
              rwds_o    <= 1'b0;
              addr_o    <= ca_addr_i;
              start_q   <= ca_addr_i[7:0] & msk;
              group_q   <= (ca_addr_i & ~mask32) + mask32 + 32'h00000001;
              wrap_q    <= wrapped;
              hyb_act_q <= wrapped & ~hyb_q;
              if (lat_txn)
              begin
                st_q  <= ST_LAT;
                cnt_q <= dbl ? (one_lat << 1) - 4'h1 : one_lat - 4'h1;
                refresh_go_o <= refresh_due_i & ~fixed_q;
              end
              else
              begin
                st_q          <= ST_DATA;
                data_phase_o  <= 1'b1;
                reg_capture_o <= 1'b1;
                refresh_go_o  <= refresh_due_i;
              end
            end
            else
              rwds_o <= fixed_q | refresh_due_i;
          end
          ST_LAT:
          begin
            if (cnt_q == 4'h0)
            begin
              st_q         <= ST_DATA;
              data_phase_o <= 1'b1;
            end
            else
              cnt_q <= cnt_q - 4'h1;
          end
          ST_DATA:
          begin
            reg_capture_o <= 1'b0;
            if (advance_i)
            begin
              if (!wrap_q)
                addr_o <= next_lin;
              else if (hyb_act_q && wrap_end)
              begin
                addr_o <= group_q;
                wrap_q <= 1'b0;
              end
              else
                addr_o <= next_wrp;
            end
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// file: sim/bsl_core_props.sv
// assertion checker for the burst sequencing and latency block
`timescale 1ns/100ps
module bsl_core_props
(
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        ca_done_i,
  input wire        ca_reg_space_i,
  input wire        ca_read_i,
  input wire [31:0] ca_addr_i,
  input wire [31:0] addr_o,
  input wire        refresh_due_i,
  input wire        rwds_o,
  input wire        rwds_oe_o,
  input wire        refresh_go_o,
  input wire        data_phase_o,
  input wire        reg_capture_o,
  input wire [3:0]  lat_code_o,
  input wire        lat_code_bad_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire lat_txn = ca_done_i && !(ca_reg_space_i && !ca_read_i);
  ////////////////////////////////////////
  a_regw_zero_lat: assert property (ca_done_i && ca_reg_space_i && !ca_read_i |=> reg_capture_o && data_phase_o)
    else $error("register write data not captured at once");
  a_capture_one: assert property (reg_capture_o |=> !reg_capture_o)
    else $error("capture pulse too long");
  a_lat_reset: assert property ($rose(rst_n_i) |-> lat_code_o == 4'h2 && !lat_code_bad_o)
    else $error("latency code wrong after reset");
  a_lat_bad: assert property (lat_code_bad_o == !(lat_code_o inside {4'h0, 4'h1, 4'h2, 4'hE, 4'hF}))
    else $error("reserved code flag wrong");
  a_lat_floor: assert property (lat_txn |=> !data_phase_o [*3])
    else $error("data phase before shortest latency");
  a_lat_ceiling: assert property (lat_txn |-> ##[4:15] data_phase_o)
    else $error("data phase after longest latency");
  a_strobe_ca: assert property (ca_done_i |=> !rwds_oe_o)
    else $error("strobe still driven after address phase");
  a_start_addr: assert property (ca_done_i |=> addr_o == $past(ca_addr_i))
    else $error("burst does not start at the given address");
  a_strobe_refresh: assert property (rwds_oe_o && $past(refresh_due_i) |-> rwds_o)
    else $error("strobe low although refresh was due");
  a_refresh_regw: assert property (ca_done_i && ca_reg_space_i && !ca_read_i && refresh_due_i
    |=> refresh_go_o && reg_capture_o)
    else $error("refresh held back during register write");
  a_refresh_pulse: assert property (refresh_go_o |=> !refresh_go_o)
    else $error("refresh start pulse too long");
  c_regw: cover property (reg_capture_o);
  c_latency: cover property (lat_txn ##[4:15] data_phase_o);
  c_strobe: cover property ($fell(rwds_oe_o));
endmodule
bind bsl_core bsl_core_props u_bsl_core_props (.*);

// file: sim/bsl_host.sv
// host controller model: frames one transfer and records the addresses
`timescale 1ns/100ps
module bsl_host
(
  input  wire        ref_clk_i,
  input  wire        data_phase_i,
  input  wire [31:0] addr_i,
  output reg         chip_sel_n_o,
  output reg         ca_done_o,
  output reg         reg_space_o,
  output reg         read_o,
  output reg         linear_o,
  output reg  [31:0] ca_addr_o,
  output reg         advance_o
);
  reg     [31:0] seen [0:79];
  integer        lat;
  integer        i;
  initial {chip_sel_n_o, ca_done_o, reg_space_o, read_o, linear_o, ca_addr_o, advance_o} = {5'h10, 32'h0, 1'h0};
  task frame(input rs, input rd, input lin, input [31:0] a, input integer n);
    begin
      @(posedge ref_clk_i) #1;
      chip_sel_n_o = 1'h0;
      {reg_space_o, read_o, linear_o, ca_addr_o} = {rs, rd, lin, a};
      // leave time for the select synchroniser
      repeat (6) @(posedge ref_clk_i);
      #1 ca_done_o = 1'h1;
      @(posedge ref_clk_i) #1 ca_done_o = 1'h0;
      lat = 0;
      while (data_phase_i !== 1'h1 && lat < 40)
      begin
        @(posedge ref_clk_i) #1;
        lat = lat + 1;
      end
      seen[0] = addr_i;
      advance_o = (n > 0);
      for (i = 1; i <= n; i = i + 1)
      begin
        @(posedge ref_clk_i) #1;
        seen[i] = addr_i;
        advance_o = (i < n);
      end
      chip_sel_n_o = 1'h1;
      repeat (8) @(posedge ref_clk_i) #1;
    end
  endtask
endmodule

// file: sim/test_bsl_core.sv
// self-checking bench for the burst sequencing and latency block
`timescale 1ns/100ps
module test_bsl_core;
  localparam [19:0] CODES = 20'h012EF;
  localparam [19:0] CLKS  = 20'h56734;
  logic        ref_clk_i = 1'h0, rst_n_i = 1'h0, refresh_due_i = 1'h0, cfg0_we_i = 1'h0, cfg1_we_i = 1'h0;
  logic [15:0] cfg0_wdata_i = 16'h0, cfg1_wdata_i = 16'h0;
  wire         chip_sel_n_i, ca_done_i, ca_reg_space_i, ca_read_i, ca_burst_linear_i, advance_i;
  wire         rwds_o, rwds_oe_o, data_phase_o, reg_capture_o, refresh_go_o, lat_code_bad_o;
  wire  [31:0] ca_addr_i, addr_o;
  wire  [3:0]  lat_code_o;
  integer      fails = 0, n_tests = 0, k, m, x;
  always #50 ref_clk_i = ~ref_clk_i;
  bsl_core u_bsl_core (.*);
  bsl_host u_host (.ref_clk_i, .data_phase_i(data_phase_o), .addr_i(addr_o), .chip_sel_n_o(chip_sel_n_i),
    .ca_done_o(ca_done_i), .reg_space_o(ca_reg_space_i), .read_o(ca_read_i), .linear_o(ca_burst_linear_i),
    .ca_addr_o(ca_addr_i), .advance_o(advance_i));
  ////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task cfg(input [3:0] lat, input fx, input hy, input [1:0] wl, input bt);
    begin
      @(posedge ref_clk_i) #1;
      {cfg0_we_i, cfg1_we_i} = 2'h3;
      cfg0_wdata_i = {8'h8F, lat, fx, hy, wl};
      cfg1_wdata_i = {8'hFF, bt, 7'h40};
      @(posedge ref_clk_i) #1 {cfg0_we_i, cfg1_we_i} = 2'h0;
    end
  endtask
  // expected address of word i; a hybrid wrap leaves to base + 2i
  function [31:0] nxt(input [31:0] s, input [31:0] len, input hyb, input lin, input [31:0] i);
    nxt = lin ? s + 2 * i : (s & ~(len - 1)) + (hyb && 2 * i >= len ? 2 * i : (s + 2 * i) % len);
  endfunction
  task burst(input [1:0] wl, input hy, input cl, input bt, input [7:0] st);
    integer len, i;
    begin
      len = wl == 2'h0 ? 128 : wl == 2'h1 ? 64 : wl == 2'h2 ? 16 : 32;
      cfg(4'hE, 1'h0, hy, wl, bt);
      u_host.frame(0, 1, cl, {24'h000012, st}, len / 2 + 6);
      for (i = 0; i <= len / 2 + 6; i = i + 1)
        chk(u_host.seen[i], nxt({24'h000012, st}, len, !hy, cl && bt, i));
    end
  endtask
  initial
  begin
    #2000000;
    fails = fails + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    #1 rst_n_i = 1'h1;
    repeat (5) @(posedge ref_clk_i) #1;
    chk(lat_code_o, 32'h2);
    for (k = 0; k < 5; k = k + 1)
      for (m = 0; m < 3; m = m + 1)
      begin
        cfg(CODES[19-4*k -: 4], m == 2, 1'h1, 2'h3, 1'h1);
        refresh_due_i = (m == 1);
        u_host.frame(k == 4, k % 2 == 1 || k == 4, 1'h1, 32'h100, 0);
        x = CLKS[19-4*k -: 4];
        // the host counts the edges from the address phase to the first data edge
        chk(u_host.lat, m > 0 ? 2 * x : x);
        chk(lat_code_o, CODES[19-4*k -: 4]);
      end
    cfg(4'h5, 1'h0, 1'h1, 2'h3, 1'h1);
    u_host.frame(0, 1, 1, 32'h100, 0);
    chk(lat_code_bad_o, 32'h1);
    chk(u_host.lat, 32'h7);
    refresh_due_i = 1'h1;
    u_host.frame(1, 0, 1, 32'h100, 0);
    chk(u_host.lat, 32'h0);
    refresh_due_i = 1'h0;
    burst(2'h2, 1'h1, 1'h0, 1'h1, 8'h0C);
    burst(2'h2, 1'h0, 1'h0, 1'h1, 8'h0C);
    burst(2'h1, 1'h0, 1'h0, 1'h0, 8'h2E);
    burst(2'h3, 1'h1, 1'h1, 1'h0, 8'h0A);
    burst(2'h0, 1'h0, 1'h0, 1'h1, 8'h46);
    burst(2'h2, 1'h0, 1'h1, 1'h1, 8'h3E);
    tally_and_finish;
  end
endmodule
